// File: line_sense_defs.svh
// Register offsets, field positions and reset values for the line sense block.
// Assumes an 8-bit register port with 6-bit addresses, as on the control port.
`ifndef LINE_SENSE_DEFS_SVH
`define LINE_SENSE_DEFS_SVH

`define ADDR_EVENT_STATUS 6'h03
`define ADDR_EVENT_IRQ_EN 6'h05
`define ADDR_LINE_SIDE_CTRL 6'h12
`define ADDR_SENSE_ENABLES 6'h15
`define ADDR_RING_RESULT 6'h1a
`define ADDR_LINE_V_RESULT 6'h1b
`define ADDR_LOOP_I_RESULT 6'h1c
`define ADDR_LINE_FAULT_STATUS 6'h1e
`define ADDR_DC_LOOP_CTRL 6'h16

`define BIT_FAULT_FLAG 2
`define BIT_FAULT_IRQ_EN 2
`define BIT_SENSORS_ON 1
`define BIT_UV_ON 2
`define BIT_OV_ON 1
`define BIT_OI_ON 0
`define BIT_UV_FLAG 6
`define BIT_OV_FLAG 5
`define BIT_OI_FLAG 4
`define BIT_BW_SELECT 0
`define BIT_FEATURE_EN 1

`define RESET_BYTE 8'h00
`define READ_ZERO 8'h00

`endif

// File: line_sense_pkg.sv
// Types shared by the line sense block.
// Assumes the defs header supplies all numeric constants.
package line_sense_pkg;

    typedef struct packed {
        logic undervolt_condition;
        logic overvolt_condition;
        logic overcurrent_condition;
    } line_conditions_t;

    typedef struct packed {
        logic [7:0] ring_voltage_sample;
        logic [7:0] line_voltage_value;
        logic [6:0] loop_current_value;
    } aux_results_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// File: cond_gate.sv
// One gated, registered line condition.
// Assumes the raw condition is synchronous to clk.
`timescale 1ns/1ps
module cond_gate (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Condition and its enables
    input wire logic raw,
    input wire logic enable,
    // Gated level
    output logic active
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active <= 1'b0;
        end else begin
            active <= raw & enable;
        end
    end
endmodule

// File: line_sense_fault_status.sv
// Line sense result registers and line fault reporting.
// Assumes a single-cycle register port, conditions from the line side
// already synchronous to clk, and aux results updated by the converter.
`timescale 1ns/1ps
`include "line_sense_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Loop current read as 7-bit magnitude in bits 7:1, about 1.25 mA per count.
// - Line voltage top seven bits in bits 7:1, count times 11 mV.
// - Ring voltage read as 8-bit ones' complement, about 10.23 mV per count.
// - Fault flag sets on any under-voltage, over-voltage or over-current.
// - Reading the status register clears the fault flag.
// - Fault interrupt only when its enable bit is one; enable resets to zero.
// - Detector conditions ignored while line sensors enable is zero.
// - Under-voltage while enabled forces wide DC loop bandwidth temporarily.
// - Under-voltage status bit follows the live under-voltage condition.
// - Over-voltage detection needs its enable, feature enable and bandwidth select.
module line_sense_fault_status (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire line_sense_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // Line side
    input wire line_sense_pkg::line_conditions_t cond_in,
    input wire line_sense_pkg::aux_results_t aux_in,
    output logic line_sensors_on,
    output logic dc_loop_bw_select,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic fault_irq_enable_r;
    logic line_sensors_on_r;
    logic undervolt_sense_on_r;
    logic overvolt_sense_on_r;
    logic overcurrent_sense_on_r;
    logic dc_loop_bw_select_r;
    logic feature_enable_bit_r;
    logic line_fault_flag_r;
    logic line_fault_flag_nxt;
    line_sense_pkg::aux_results_t aux_r;
    // Condition path
    logic uv_enable;
    logic ov_enable;
    logic oi_enable;
    logic uv_active;
    logic ov_active;
    logic oi_active;
    logic any_fault;
    logic status_read;
    // Readback path
    logic [7:0] event_status_byte;
    logic [7:0] irq_enable_byte;
    logic [7:0] loop_current_byte;
    logic [7:0] line_fault_status_byte;
    logic [7:0] read_byte;

    // Fault interrupt enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_irq_enable_r <= 1'b0;
        end else if (req.wr && req.addr == `ADDR_EVENT_IRQ_EN) begin
            fault_irq_enable_r <= req.wdata[`BIT_FAULT_IRQ_EN];
        end
    end

    // Line sensors master enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_sensors_on_r <= 1'b0;
        end else if (req.wr && req.addr == `ADDR_LINE_SIDE_CTRL) begin
            line_sensors_on_r <= req.wdata[`BIT_SENSORS_ON];
        end
    end

    // Per-detector enables
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            undervolt_sense_on_r <= 1'b0;
            overvolt_sense_on_r <= 1'b0;
            overcurrent_sense_on_r <= 1'b0;
        end else if (req.wr && req.addr == `ADDR_SENSE_ENABLES) begin
            undervolt_sense_on_r <= req.wdata[`BIT_UV_ON];
            overvolt_sense_on_r <= req.wdata[`BIT_OV_ON];
            overcurrent_sense_on_r <= req.wdata[`BIT_OI_ON];
        end
    end

    // Bandwidth and feature bits live elsewhere in the full device; kept here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dc_loop_bw_select_r <= 1'b0;
            feature_enable_bit_r <= 1'b0;
        end else if (req.wr && req.addr == `ADDR_DC_LOOP_CTRL) begin
            dc_loop_bw_select_r <= req.wdata[`BIT_BW_SELECT];
            feature_enable_bit_r <= req.wdata[`BIT_FEATURE_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition gating
    // A condition counts only while every enable on its path is set
    assign uv_enable = line_sensors_on_r & undervolt_sense_on_r;
    assign ov_enable = line_sensors_on_r & overvolt_sense_on_r
                       & feature_enable_bit_r & dc_loop_bw_select_r;
    assign oi_enable = line_sensors_on_r & overcurrent_sense_on_r;

    cond_gate u_uv (
        .clk(clk),
        .rst_b(rst_b),
        .raw(cond_in.undervolt_condition),
        .enable(uv_enable),
        .active(uv_active)
    );

    cond_gate u_ov (
        .clk(clk),
        .rst_b(rst_b),
        .raw(cond_in.overvolt_condition),
        .enable(ov_enable),
        .active(ov_active)
    );

    cond_gate u_oi (
        .clk(clk),
        .rst_b(rst_b),
        .raw(cond_in.overcurrent_condition),
        .enable(oi_enable),
        .active(oi_active)
    );

    assign any_fault = uv_active | ov_active | oi_active;
    // Only a read of the status register clears the flag
    assign status_read = req.rd && req.addr == `ADDR_EVENT_STATUS;

    ////////////////////////////////////////////////////////////////////////////
    // Fault flag; a live fault re-sets it in the same cycle as the clearing read
    always_comb begin
        line_fault_flag_nxt = line_fault_flag_r;
        if (status_read) begin
            line_fault_flag_nxt = 1'b0;
        end
        if (any_fault) begin
            line_fault_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_fault_flag_r <= 1'b0;
        end else begin
            line_fault_flag_r <= line_fault_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter results captured each cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aux_r <= '0;
        end else begin
            aux_r <= aux_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback bytes; bits with no field read as zero
    always_comb begin
        event_status_byte = `READ_ZERO;
        event_status_byte[`BIT_FAULT_FLAG] = line_fault_flag_r;
    end

    always_comb begin
        irq_enable_byte = `READ_ZERO;
        irq_enable_byte[`BIT_FAULT_IRQ_EN] = fault_irq_enable_r;
    end

    always_comb begin
        line_fault_status_byte = `READ_ZERO;
        line_fault_status_byte[`BIT_UV_FLAG] = uv_active;
        line_fault_status_byte[`BIT_OV_FLAG] = ov_active;
        line_fault_status_byte[`BIT_OI_FLAG] = oi_active;
    end

    // Magnitude only; bit 0 carries no weight
    assign loop_current_byte = {aux_r.loop_current_value, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; write-only and unmapped addresses read zero
    always_comb begin
        unique case (req.addr)
            `ADDR_EVENT_STATUS: read_byte = event_status_byte;
            `ADDR_EVENT_IRQ_EN: read_byte = irq_enable_byte;
            `ADDR_RING_RESULT: read_byte = aux_r.ring_voltage_sample;
            `ADDR_LINE_V_RESULT: read_byte = aux_r.line_voltage_value;
            `ADDR_LOOP_I_RESULT: read_byte = loop_current_byte;
            `ADDR_LINE_FAULT_STATUS: read_byte = line_fault_status_byte;
            default: read_byte = `READ_ZERO;
        endcase
    end

    // Registered so read data holds until the next read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= `RESET_BYTE;
        end else if (req.rd) begin
            rdata <= read_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign line_sensors_on = line_sensors_on_r;
    // Wide bandwidth forced only while the under-voltage lasts
    assign dc_loop_bw_select = dc_loop_bw_select_r | uv_active;
    assign irq = line_fault_flag_r & fault_irq_enable_r;

endmodule

// File: line_side_model.sv
// Line-side stand-in: fault levels and converter results.
// Assumes the bench sets levels at the falling edge.
`timescale 1ns/1ps
module line_side_model (
    // Wanted levels
    input wire line_sense_pkg::line_conditions_t cond_set,
    input wire line_sense_pkg::aux_results_t aux_set,
    // To the block
    output line_sense_pkg::line_conditions_t cond_in,
    output line_sense_pkg::aux_results_t aux_in
);
    assign cond_in = cond_set;
    assign aux_in = aux_set;
endmodule

// File: line_sense_chk.sv
// Port checker for the line sense block.
// Assumes a one-cycle register port and registered read data.
`timescale 1ns/1ps
module line_sense_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire line_sense_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire line_sense_pkg::line_conditions_t cond_in,
    input wire line_sense_pkg::aux_results_t aux_in,
    input wire logic line_sensors_on,
    input wire logic dc_loop_bw_select,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !line_sensors_on)
        else $error("outputs high after reset");
    a_sensors_write: assert property (req.wr && req.addr == 6'h12 |=>
        line_sensors_on == $past(req.wdata[1])) else $error("sensor enable lost");
    a_read_clears: assert property ((cond_in == 3'b000) [*3] ##0
        (req.rd && req.addr == 6'h03) |=> !irq) else $error("irq after clear");
    a_loop_current: assert property (req.rd && req.addr == 6'h1c && $stable(aux_in) &&
        $past(rst_b) |=> rdata[7:1] == $past(aux_in.loop_current_value))
        else $error("loop current wrong");
    a_line_volts: assert property (req.rd && req.addr == 6'h1b && $stable(aux_in) &&
        $past(rst_b) |=> rdata[7:1] == $past(aux_in.line_voltage_value[7:1]))
        else $error("line voltage wrong");
    a_ring_volts: assert property (req.rd && req.addr == 6'h1a && $stable(aux_in) &&
        $past(rst_b) |=> rdata == $past(aux_in.ring_voltage_sample)) else $error("ring");
    a_gated_status: assert property (!line_sensors_on [*3] ##0
        (req.rd && req.addr == 6'h1e) |=> rdata == 8'h00) else $error("status leak");
    a_bw_by_write: assert property (!line_sensors_on [*3] ##0 $rose(dc_loop_bw_select)
        |-> $past(req.wr) && $past(req.addr) == 6'h16) else $error("bw rose");
endmodule
bind line_sense_fault_status line_sense_chk chk (.clk(clk), .rst_b(rst_b), .req(req),
    .rdata(rdata), .cond_in(cond_in), .aux_in(aux_in), .line_sensors_on(line_sensors_on),
    .dc_loop_bw_select(dc_loop_bw_select), .irq(irq));

// File: line_sense_fault_status_test.sv
// Bench for the line sense block: register tasks and fault pulses.
// Assumes one-cycle strobes and read data one edge after the strobe.
`timescale 1ns/1ps
module line_sense_fault_status_test;
    logic clk = 1'b1;
    logic rst_b = 1'b0;
    line_sense_pkg::reg_req_t req = '0;
    line_sense_pkg::line_conditions_t cond_set = '0;
    line_sense_pkg::aux_results_t aux_set = '0;
    line_sense_pkg::line_conditions_t cond_in;
    line_sense_pkg::aux_results_t aux_in;
    logic [7:0] rdata;
    logic sens;
    logic bw;
    logic irq;
    int error_cnt = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    line_side_model model (.cond_set(cond_set), .aux_set(aux_set), .cond_in(cond_in),
        .aux_in(aux_in));
    line_sense_fault_status dut (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .cond_in(cond_in), .aux_in(aux_in), .line_sensors_on(sens),
        .dc_loop_bw_select(bw), .irq(irq));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{r, !r, a, d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        acc(1'b1, a, 8'h00);
        check(rdata & m, e);
    endtask
    // Pulse lasts one sampled edge, the shortest fault the line side sends
    task automatic pulse(input logic [2:0] c);
        @(negedge clk);
        cond_set = c;
        @(negedge clk);
        cond_set = '0;
        repeat (3) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        rd(6'h03, 8'h00);
        rd(6'h05, 8'h00);
        rd(6'h00, 8'h00);
        acc(1'b0, 6'h16, 8'h01);
        check({7'h0, bw}, 8'h01);
        acc(1'b0, 6'h16, 8'h00);
        aux_set = {8'h9c, 8'ha5, 7'h55};
        cond_set = 3'b100;
        rd(6'h1a, 8'h9c);
        rd(6'h1b, 8'ha4, 8'hfe);
        rd(6'h1c, 8'haa, 8'hfe);
        rd(6'h1e, 8'h00);
        rd(6'h03, 8'h00);
        acc(1'b0, 6'h12, 8'h02);
        check({7'h0, sens}, 8'h01);
        acc(1'b0, 6'h15, 8'h07);
        acc(1'b0, 6'h05, 8'h04);
        rd(6'h05, 8'h04);
        rd(6'h1e, 8'h40);
        check({6'h0, bw, irq}, 8'h03);
        cond_set = 3'b000;
        rd(6'h12, 8'h00);
        check({7'h0, bw}, 8'h00);
        rd(6'h03, 8'h04);
        rd(6'h03, 8'h00);
        check({7'h0, irq}, 8'h00);
        pulse(3'b010);
        rd(6'h03, 8'h00);
        acc(1'b0, 6'h16, 8'h03);
        for (int i = 0; i < 3; i++) begin
            pulse(3'b001 << i);
            check({7'h0, irq}, 8'h01);
            rd(6'h03, 8'h04);
            rd(6'h03, 8'h00);
        end
        acc(1'b0, 6'h05, 8'h00);
        pulse(3'b001);
        check({7'h0, irq}, 8'h00);
        rd(6'h03, 8'h04);
        tally_and_finish();
    end
endmodule
